// File: mit_map.svh
`ifndef MIT_MAP_SVH
`define MIT_MAP_SVH

// instruction cycle: four system clock periods, phases 0..3
`define MIT_CLKS_PER_CYCLE 4
`define MIT_PHASE_EXEC     2'h2
`define MIT_PHASE_FETCH    2'h3

// reset values
`define MIT_PC_RESET       11'h000
`define MIT_BYTE_RESET     8'h00
`define MIT_WORD_RESET     16'h0000

// data memory byte whose write loads the low program counter byte
`define MIT_PCL_ADDR       8'h06

// instruction word fields
`define MIT_OP_MSB         15
`define MIT_OP_LSB         11
`define MIT_DEST_BIT       10
`define MIT_BIT_MSB        10
`define MIT_BIT_LSB        8
`define MIT_SYS_MSB        10
`define MIT_SYS_LSB        9

`endif

// File: mit_pkg.sv
package mit_pkg;

	// opcode in word bits 15:11, codes follow declaration order
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD_M, OP_ADC_M, OP_SUB_M, OP_SBC_M, OP_AND_M, OP_OR_M, OP_XOR_M,
		OP_CPL, OP_INC, OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC, OP_MOV_AM,
		OP_MOV_MA, OP_ADD_X, OP_SUB_X, OP_AND_X, OP_OR_X, OP_XOR_X, OP_MOV_X, OP_SET,
		OP_CLR, OP_SZ_BIT, OP_SNZ_BIT, OP_SZ, OP_SNZ, OP_JMP, OP_CALL, OP_SYS
	} mit_op_t;

	// sub-operation of OP_SYS in word bits 10:9
	typedef enum logic [1:0] {
		SYS_RET, SYS_RETURN_FROM_INTERRUPT, SYS_TABRD, SYS_HALT
	} mit_sys_t;

	typedef enum logic [1:0] {
		ST_RUN, ST_TABLE, ST_HALT
	} mit_state_t;

endpackage : mit_pkg

// File: mit_core.sv
`timescale 1ns/1ps
`include "mit_map.svh"
// Summary of operation
// - most instructions one cycle, branches two
// - instruction cycle equals four system clocks
// - low program counter write jumps, extra cycle
// - taken skip costs one extra cycle
// - carry above 255, borrow below zero
// - increment or decrement by exactly one
// - logical results set zero flag when zero
// - rotates shift one bit, carry variants chain
// - accumulator is operand or destination
// - moves between register, accumulator, immediate
// - call saves return point, jump does not
// - conditional skips test byte or bit
// - bit set and clear keep other bits
// - table read fetches program memory constants
// - halt enters power-down state
// - interrupt return sets global interrupt enable
// - additions update all five arithmetic flags
module mit_core
	import mit_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	output logic [10:0]      pm_addr,
	input  wire logic [15:0] pm_rdata,
	output logic [7:0]       dm_addr,
	input  wire logic [7:0]  dm_rdata,
	output logic [7:0]       dm_wdata,
	output logic             dm_we,
	output logic [7:0]       acc,
	output logic             zero_flag,
	output logic             carry_flag,
	output logic             auxiliary_carry_flag,
	output logic             overflow_flag,
	output logic             signed_compare_flag,
	output logic             global_interrupt_enable,
	output logic [7:0]       table_high_byte,
	output logic             halted
);

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	// {carry, half carry, overflow, sum}; subtraction passes ~b and ~borrow
	function automatic logic [10:0] mit_add(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] sum;
		logic [4:0] half;
		logic       ov;
		sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		ov   = (a[7] == b[7]) && (sum[7] != a[7]);
		return {sum[8], half[4], ov, sum[7:0]};
	endfunction : mit_add

	logic [1:0]  phase_ff, nxt_phase;
	mit_state_t  state_ff, nxt_state;
	logic [10:0] pc_ff, nxt_pc, pm_addr_ff, nxt_pm_addr, target_ff, nxt_target;
	logic [15:0] ir_ff, nxt_ir;
	logic        valid_ff, nxt_valid, jump_ff, nxt_jump, tbl_req_ff, nxt_tbl_req;
	logic [7:0]  acc_ff, nxt_acc, dm_addr_ff, nxt_dm_addr, wdata_ff, nxt_wdata;
	logic [7:0]  tbl_hi_ff, nxt_tbl_hi, tbl_ptr_ff, nxt_tbl_ptr;
	logic        we_ff, nxt_we, gie_ff, nxt_gie;
	logic        z_ff, nxt_z, c_ff, nxt_c, ac_ff, nxt_ac, ov_ff, nxt_ov, sc_ff, nxt_sc;
	logic [10:0] stk_ff [STACK_DEPTH];
	logic [10:0] nxt_stk [STACK_DEPTH];
	logic [SP_W-1:0] sp_ff, nxt_sp;

	mit_op_t     op;
	mit_sys_t    sys;
	logic [2:0]  bit_sel;
	logic        to_mem;

	assign op      = mit_op_t'(ir_ff[`MIT_OP_MSB:`MIT_OP_LSB]);
	assign sys     = mit_sys_t'(ir_ff[`MIT_SYS_MSB:`MIT_SYS_LSB]);
	assign bit_sel = ir_ff[`MIT_BIT_MSB:`MIT_BIT_LSB];
	assign to_mem  = ir_ff[`MIT_DEST_BIT];

	// execute at phase 2, fetch and redirect at phase 3
	always_comb begin
		logic [10:0] alu;
		logic [7:0]  res;
		logic        wr_mem;
		logic        wr_acc;
		logic        skip;
		logic        redirect;
		logic [10:0] dest;
		alu         = 11'h000;
		res         = 8'h00;
		wr_mem      = 1'b0;
		wr_acc      = 1'b0;
		skip        = 1'b0;
		redirect    = 1'b0;
		dest        = pc_ff;
		nxt_phase   = phase_ff + 2'h1;
		nxt_state   = state_ff;
		nxt_pc      = pc_ff;
		nxt_pm_addr = pm_addr_ff;
		nxt_target  = target_ff;
		nxt_ir      = ir_ff;
		nxt_valid   = valid_ff;
		nxt_jump    = jump_ff;
		nxt_tbl_req = tbl_req_ff;
		nxt_acc     = acc_ff;
		nxt_dm_addr = dm_addr_ff;
		nxt_wdata   = wdata_ff;
		nxt_tbl_hi  = tbl_hi_ff;
		nxt_tbl_ptr = tbl_ptr_ff;
		nxt_we      = 1'b0;
		nxt_gie     = gie_ff;
		nxt_z       = z_ff;
		nxt_c       = c_ff;
		nxt_ac      = ac_ff;
		nxt_ov      = ov_ff;
		nxt_sc      = sc_ff;
		nxt_stk     = stk_ff;
		nxt_sp      = sp_ff;

		if (phase_ff == `MIT_PHASE_EXEC && state_ff == ST_RUN && valid_ff) begin
			unique case (op)
				OP_NOP: begin
				end
				OP_ADD_M, OP_ADC_M, OP_ADD_X: begin
					alu = mit_add(acc_ff, (op == OP_ADD_X) ? ir_ff[7:0] : dm_rdata,
						(op == OP_ADC_M) & c_ff);
					res = alu[7:0];
					nxt_c  = alu[10];
					nxt_ac = alu[9];
					nxt_ov = alu[8];
					nxt_sc = alu[8] ^ res[7];
					nxt_z  = (res == 8'h00);
					wr_mem = to_mem && (op != OP_ADD_X);
					wr_acc = !wr_mem;
				end
				OP_SUB_M, OP_SBC_M, OP_SUB_X: begin
					// carry flag holds borrow: set when the difference drops below zero
					alu = mit_add(acc_ff, ~((op == OP_SUB_X) ? ir_ff[7:0] : dm_rdata),
						~((op == OP_SBC_M) & c_ff));
					res = alu[7:0];
					nxt_c  = ~alu[10];
					nxt_ac = ~alu[9];
					nxt_ov = alu[8];
					nxt_sc = alu[8] ^ res[7];
					nxt_z  = (res == 8'h00);
					wr_mem = to_mem && (op != OP_SUB_X);
					wr_acc = !wr_mem;
				end
				OP_AND_M, OP_OR_M, OP_XOR_M, OP_AND_X, OP_OR_X, OP_XOR_X, OP_CPL: begin
					unique case (op)
						OP_AND_M: res = acc_ff & dm_rdata;
						OP_OR_M:  res = acc_ff | dm_rdata;
						OP_XOR_M: res = acc_ff ^ dm_rdata;
						OP_AND_X: res = acc_ff & ir_ff[7:0];
						OP_OR_X:  res = acc_ff | ir_ff[7:0];
						OP_XOR_X: res = acc_ff ^ ir_ff[7:0];
						default:  res = ~dm_rdata;
					endcase
					nxt_z  = (res == 8'h00);
					wr_mem = to_mem && (op inside {OP_AND_M, OP_OR_M, OP_XOR_M, OP_CPL});
					wr_acc = !wr_mem;
				end
				OP_INC, OP_DEC: begin
					res    = (op == OP_INC) ? dm_rdata + 8'h01 : dm_rdata - 8'h01;
					nxt_z  = (res == 8'h00);
					wr_mem = to_mem;
					wr_acc = !to_mem;
				end
				OP_RR, OP_RL, OP_RRC, OP_RLC: begin
					unique case (op)
						OP_RR:   res = {dm_rdata[0], dm_rdata[7:1]};
						OP_RL:   res = {dm_rdata[6:0], dm_rdata[7]};
						OP_RRC:  res = {c_ff, dm_rdata[7:1]};
						default: res = {dm_rdata[6:0], c_ff};
					endcase
					if (op == OP_RRC) begin
						nxt_c = dm_rdata[0];
					end else if (op == OP_RLC) begin
						nxt_c = dm_rdata[7];
					end
					wr_mem = to_mem;
					wr_acc = !to_mem;
				end
				OP_MOV_AM, OP_MOV_X: begin
					res    = (op == OP_MOV_X) ? ir_ff[7:0] : dm_rdata;
					wr_acc = 1'b1;
				end
				OP_MOV_MA: begin
					res    = acc_ff;
					wr_mem = 1'b1;
				end
				OP_SET, OP_CLR: begin
					// read-modify-write inside the core, only the chosen bit moves
					res          = dm_rdata;
					res[bit_sel] = (op == OP_SET);
					wr_mem       = 1'b1;
				end
				OP_SZ_BIT, OP_SNZ_BIT, OP_SZ, OP_SNZ: begin
					unique case (op)
						OP_SZ_BIT:  skip = !dm_rdata[bit_sel];
						OP_SNZ_BIT: skip = dm_rdata[bit_sel];
						OP_SZ:      skip = (dm_rdata == 8'h00);
						default:    skip = (dm_rdata != 8'h00);
					endcase
					res    = dm_rdata;
					wr_acc = to_mem && (op inside {OP_SZ, OP_SNZ});
				end
				OP_JMP: begin
					redirect = 1'b1;
					dest     = ir_ff[10:0];
				end
				OP_CALL: begin
					// pc already points past the call: that is the return point
					nxt_stk[sp_ff] = pc_ff;
					nxt_sp         = sp_ff + SP_W'(1);
					redirect       = 1'b1;
					dest           = ir_ff[10:0];
				end
				OP_SYS: begin
					unique case (sys)
						SYS_RET, SYS_RETURN_FROM_INTERRUPT: begin
							nxt_sp   = sp_ff - SP_W'(1);
							dest     = stk_ff[sp_ff - SP_W'(1)];
							redirect = 1'b1;
							if (sys == SYS_RETURN_FROM_INTERRUPT) begin
								nxt_gie = 1'b1;
							end
						end
						SYS_TABRD: begin
							nxt_tbl_ptr = dm_rdata;
							nxt_tbl_req = 1'b1;
						end
						SYS_HALT: begin
							nxt_state = ST_HALT;
						end
					endcase
				end
			endcase
			if (wr_acc) begin
				nxt_acc = res;
			end
			if (wr_mem) begin
				nxt_wdata = res;
				nxt_we    = 1'b1;
				if (dm_addr_ff == `MIT_PCL_ADDR) begin
					redirect = 1'b1;
					dest     = {pc_ff[10:8], res};
				end
			end
			// a taken skip drops the prefetched word, pc points at it so the target is pc plus one
			if (skip) begin
				nxt_jump   = 1'b1;
				nxt_target = pc_ff + 11'h001;
			end
			if (redirect) begin
				nxt_jump   = 1'b1;
				nxt_target = dest;
			end
		end

		if (phase_ff == `MIT_PHASE_FETCH) begin
			unique case (state_ff)
				ST_RUN: begin
					// the word on the bus is the prefetch; a pending redirect voids it
					nxt_ir      = pm_rdata;
					nxt_dm_addr = pm_rdata[7:0];
					nxt_valid   = !jump_ff;
					nxt_pc      = jump_ff ? target_ff : pc_ff + 11'h001;
					nxt_pm_addr = nxt_pc;
					nxt_jump    = 1'b0;
					if (tbl_req_ff) begin
						nxt_pm_addr = {pc_ff[10:8], tbl_ptr_ff};
						nxt_tbl_req = 1'b0;
						nxt_state   = ST_TABLE;
					end
				end
				ST_TABLE: begin
					// second cycle of a table read: prefetched instruction is kept
					nxt_acc     = pm_rdata[7:0];
					nxt_tbl_hi  = pm_rdata[15:8];
					nxt_pm_addr = pc_ff;
					nxt_state   = ST_RUN;
				end
				default: begin
				end
			endcase
		end
	end

	// state registers; power-down is left only by reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			phase_ff   <= 2'h0;
			state_ff   <= ST_RUN;
			pc_ff      <= `MIT_PC_RESET;
			pm_addr_ff <= `MIT_PC_RESET;
			target_ff  <= `MIT_PC_RESET;
			ir_ff      <= `MIT_WORD_RESET;
			valid_ff   <= 1'b0;
			jump_ff    <= 1'b0;
			tbl_req_ff <= 1'b0;
			acc_ff     <= `MIT_BYTE_RESET;
			dm_addr_ff <= `MIT_BYTE_RESET;
			wdata_ff   <= `MIT_BYTE_RESET;
			tbl_hi_ff  <= `MIT_BYTE_RESET;
			tbl_ptr_ff <= `MIT_BYTE_RESET;
			we_ff      <= 1'b0;
			gie_ff     <= 1'b0;
			z_ff       <= 1'b0;
			c_ff       <= 1'b0;
			ac_ff      <= 1'b0;
			ov_ff      <= 1'b0;
			sc_ff      <= 1'b0;
			sp_ff      <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stk_ff[i] <= `MIT_PC_RESET;
			end
		end else begin
			phase_ff   <= nxt_phase;
			state_ff   <= nxt_state;
			pc_ff      <= nxt_pc;
			pm_addr_ff <= nxt_pm_addr;
			target_ff  <= nxt_target;
			ir_ff      <= nxt_ir;
			valid_ff   <= nxt_valid;
			jump_ff    <= nxt_jump;
			tbl_req_ff <= nxt_tbl_req;
			acc_ff     <= nxt_acc;
			dm_addr_ff <= nxt_dm_addr;
			wdata_ff   <= nxt_wdata;
			tbl_hi_ff  <= nxt_tbl_hi;
			tbl_ptr_ff <= nxt_tbl_ptr;
			we_ff      <= nxt_we;
			gie_ff     <= nxt_gie;
			z_ff       <= nxt_z;
			c_ff       <= nxt_c;
			ac_ff      <= nxt_ac;
			ov_ff      <= nxt_ov;
			sc_ff      <= nxt_sc;
			sp_ff      <= nxt_sp;
			stk_ff     <= nxt_stk;
		end
	end

	// all outputs but halted come straight from flip-flops; halted decodes state_ff
	assign pm_addr                 = pm_addr_ff;
	assign dm_addr                 = dm_addr_ff;
	assign dm_wdata                = wdata_ff;
	assign dm_we                   = we_ff;
	assign acc                     = acc_ff;
	assign zero_flag               = z_ff;
	assign carry_flag              = c_ff;
	assign auxiliary_carry_flag    = ac_ff;
	assign overflow_flag           = ov_ff;
	assign signed_compare_flag     = sc_ff;
	assign global_interrupt_enable = gie_ff;
	assign table_high_byte         = tbl_hi_ff;
	assign halted                  = (state_ff == ST_HALT);

endmodule : mit_core

// File: mit_mem.sv
`timescale 1ns/1ps
// program and data memory of the core; reads answer at once, the fastest case
module mit_mem (
	input  wire logic        clk,
	input  wire logic [10:0] pm_addr,
	output logic      [15:0] pm_rdata,
	input  wire logic [7:0]  dm_addr,
	output logic      [7:0]  dm_rdata,
	input  wire logic [7:0]  dm_wdata,
	input  wire logic        dm_we
);
	logic [15:0] pmem [2048];
	logic [7:0]  dmem [256];

	// table words live in the same array as code
	assign pm_rdata = pmem[pm_addr];
	assign dm_rdata = dmem[dm_addr];

	// byte write at the edge that ends phase three
	always @(posedge clk) begin
		if (dm_we) begin
			dmem[dm_addr] <= dm_wdata;
		end
	end
endmodule : mit_mem

// File: mit_core_properties.sv
`timescale 1ns/1ps
`include "mit_map.svh"
module mit_core_properties #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [10:0] pm_addr,
	input wire logic [7:0]  dm_addr,
	input wire logic [7:0]  dm_wdata,
	input wire logic        dm_we,
	input wire logic [7:0]  acc,
	input wire logic        zero_flag,
	input wire logic        carry_flag,
	input wire logic        global_interrupt_enable,
	input wire logic        halted
);
	logic [7:0] pcl_ff;
	logic [7:0] nxt_pcl;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// last value written to the low pc byte, target of the redirect
	always_comb begin
		nxt_pcl = pcl_ff;
		if (dm_we && dm_addr == `MIT_PCL_ADDR) begin
			nxt_pcl = dm_wdata;
		end
	end
	always_ff @(posedge clk) begin
		pcl_ff <= nxt_pcl;
	end

	sequence s_boot;
		(pm_addr == 11'h000 && !dm_we) [*4] ##1 pm_addr == 11'h001;
	endsequence
	sequence s_quiet3;
		!dm_we [*3];
	endsequence

	a_boot_fetch: assert property ($rose(rstn) |-> s_boot)
		else $error("first fetch not at four clocks after reset");
	a_fetch_stands: assert property (!$stable(pm_addr) |-> ##1 $stable(pm_addr) [*3])
		else $error("fetch address held less than one instruction cycle");
	a_write_spacing: assert property (dm_we |=> s_quiet3)
		else $error("data writes closer than one instruction cycle");
	a_pcl_redirect: assert property (dm_we && dm_addr == `MIT_PCL_ADDR |->
		##[1:5] pm_addr[7:0] == pcl_ff)
		else $error("low pc byte write did not redirect fetch");
	a_gie_no_fall: assert property (!$fell(global_interrupt_enable))
		else $error("interrupt enable cleared");
	a_halt_stays: assert property (halted |=> halted)
		else $error("power-down left without reset");
	a_halt_no_write: assert property (halted |-> !dm_we)
		else $error("data write in power-down");
	a_halt_frozen: assert property (halted |=> $stable({acc, zero_flag, carry_flag}))
		else $error("state changed in power-down");
endmodule : mit_core_properties

bind mit_core mit_core_properties #(.STACK_DEPTH(STACK_DEPTH)) u_props (
	.clk(clk), .rstn(rstn), .pm_addr(pm_addr), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
	.dm_we(dm_we), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
	.global_interrupt_enable(global_interrupt_enable), .halted(halted)
);

// File: mit_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module mit_core_tb_top;
	import mit_pkg::*;
	typedef struct {logic [7:0] ad; logic [7:0] d; int g;} mit_note_t;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [10:0] pm_addr;
	logic [15:0] pm_rdata;
	logic [7:0]  dm_addr, dm_rdata, dm_wdata, acc, table_high_byte;
	logic        dm_we, zero_flag, carry_flag, auxiliary_carry_flag, overflow_flag;
	logic        signed_compare_flag, global_interrupt_enable, halted;
	int          n_mismatch, checks_done, pc, pend, gap;
	logic [31:0] seed = 32'h85077D26;
	logic [15:0] w;
	logic [7:0]  a, m, r, ad;
	logic [2:0]  b;
	logic        c, sk;
	logic [4:0]  hb;
	logic        ov_x, sc_x;
	mit_note_t   q[$];
	mit_note_t   nt;

	always #50 clk = ~clk;

	mit_core DUT (.clk(clk), .rstn(rstn), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we),
		.acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
		.auxiliary_carry_flag(auxiliary_carry_flag), .overflow_flag(overflow_flag),
		.signed_compare_flag(signed_compare_flag), .halted(halted),
		.global_interrupt_enable(global_interrupt_enable), .table_high_byte(table_high_byte));
	mit_mem u_mem (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
		.dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// reference result {carry, byte}; carry on subtraction means borrow
	function automatic logic [8:0] alu(mit_op_t op, logic [7:0] x, logic [7:0] y, logic ci);
		case (op)
			OP_ADD_M: return {1'b0, x} + {1'b0, y};
			OP_ADC_M: return {1'b0, x} + {1'b0, y} + {8'h00, ci};
			OP_SUB_M: return {1'b0, x} - {1'b0, y};
			OP_SBC_M: return {1'b0, x} - {1'b0, y} - {8'h00, ci};
			OP_AND_M: return {ci, x & y};
			OP_OR_M:  return {ci, x | y};
			OP_XOR_M: return {ci, x ^ y};
			OP_CPL:   return {ci, ~y};
			OP_INC:   return {ci, y + 8'h01};
			OP_DEC:   return {ci, y - 8'h01};
			OP_RR:    return {ci, y[0], y[7:1]};
			OP_RL:    return {ci, y[6:0], y[7]};
			OP_RRC:   return {y[0], ci, y[7:1]};
			default:  return {y[7], y[6:0], ci};
		endcase
	endfunction : alu

	// one program word, plus its cycle cost since the last write
	task automatic put(mit_op_t op, logic [2:0] f, logic [7:0] o, int cyc);
		u_mem.pmem[pc] = {op, f, o};
		pc++;
		pend += cyc;
	endtask : put

	task automatic expw(logic [7:0] xa, logic [7:0] xd);
		q.push_back('{xa, xd, pend * 4});
		pend = 0;
	endtask : expw

	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up

	// each write is matched with the oldest note; pc byte writes only redirect
	always @(posedge clk) begin
		gap++;
		if (rstn && dm_we && dm_addr !== 8'h06) begin
			if (q.size() == 0) `CHK("extra write", 1'b0, 1'b1)
			else begin
				nt = q.pop_front();
				`CHK("write address", nt.ad, dm_addr)
				`CHK("write data", nt.d, dm_wdata)
				if (nt.g > 0) `CHK("write spacing", nt.g, gap)
			end
			gap = 0;
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		foreach (u_mem.pmem[i]) u_mem.pmem[i] = 16'h0000;
		foreach (u_mem.dmem[i]) u_mem.dmem[i] = 8'h00;
		pc = 0;
		pend = -100; // first spacing includes the boot bubble, not checked
		c = 1'b0;
		a = rnd();
		put(OP_MOV_X, 3'h0, a, 1);
		// every memory-destination operation, carry chained through
		for (int i = 1; i < 15; i++) begin
			m = rnd();
			ad = 8'h40 + 8'(i);
			u_mem.dmem[ad] = m;
			put(mit_op_t'(i), 3'h4, ad, 1);
			// half borrow of the last subtract with borrow, taken before carry moves on
			if (i == 4) hb = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, c};
			{c, r} = alu(mit_op_t'(i), a, m, c);
			if (i == 4) begin
				ov_x = (a[7] != m[7]) && (r[7] != a[7]);
				sc_x = ov_x ^ r[7];
			end
			expw(ad, r);
		end
		a = rnd();
		u_mem.dmem[8'h60] = a;
		put(OP_MOV_AM, 3'h0, 8'h60, 1);
		put(OP_MOV_MA, 3'h0, 8'h61, 1);
		expw(8'h61, a);
		for (int k = 0; k < 2; k++) begin
			m = rnd();
			b = rnd();
			u_mem.dmem[8'h62 + k] = m;
			put(k ? OP_CLR : OP_SET, b, 8'h62 + 8'(k), 1);
			m[b] = (k == 0);
			expw(8'h62 + 8'(k), m);
		end
		// every skip kind, each once on a zero byte and once on a random byte
		for (int n = 0; n < 8; n++) begin
			m = n[2] ? rnd() : 8'h00;
			b = rnd();
			u_mem.dmem[8'h30 + n] = m;
			case (n[1:0])
				2'h0: sk = !m[b];
				2'h1: sk = m[b];
				2'h2: sk = (m == 8'h00);
				default: sk = (m != 8'h00);
			endcase
			// whole-byte skips also copy the tested byte into the accumulator
			put(mit_op_t'(OP_SZ_BIT + n[1:0]), n[1] ? 3'h4 : b, 8'h30 + 8'(n), sk ? 2 : 1);
			if (n[1]) a = m;
			put(OP_MOV_MA, 3'h0, sk ? 8'h7F : 8'h70 + 8'(n), sk ? 0 : 1);
			if (!sk) expw(8'h70 + 8'(n), a);
		end
		put(OP_JMP, 3'h0, 8'(pc + 2), 2);
		put(OP_MOV_MA, 3'h0, 8'h7F, 0);
		put(OP_CALL, 3'h1, 8'h00, 2);
		ad = 8'(pc);
		pc = 11'h100;
		a = rnd();
		put(OP_MOV_X, 3'h0, a, 1);
		put(OP_MOV_MA, 3'h0, 8'h51, 1);
		expw(8'h51, a);
		put(OP_SYS, {SYS_RETURN_FROM_INTERRUPT, 1'b0}, 8'h00, 2);
		pc = ad;
		put(OP_MOV_MA, 3'h0, 8'h52, 1);
		expw(8'h52, a);
		a = 8'(pc + 3);
		put(OP_MOV_X, 3'h0, a, 1);
		put(OP_MOV_MA, 3'h0, 8'h06, 2);
		put(OP_MOV_MA, 3'h0, 8'h7F, 0);
		put(OP_MOV_MA, 3'h0, 8'h53, 1);
		expw(8'h53, a);
		w = {rnd(), rnd()};
		u_mem.pmem[11'h0F0] = w;
		u_mem.dmem[8'h54] = 8'hF0;
		put(OP_SYS, {SYS_TABRD, 1'b0}, 8'h54, 2);
		put(OP_MOV_MA, 3'h0, 8'h55, 1);
		expw(8'h55, w[7:0]);
		put(OP_XOR_X, 3'h0, w[7:0], 1);
		put(OP_SYS, {SYS_HALT, 1'b0}, 8'h00, 1);
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int t = 0; t < 4000 && halted !== 1'b1; t++) @(posedge clk);
		repeat (20) @(posedge clk);
		`CHK("halted", 1'b1, halted)
		`CHK("interrupt enable", 1'b1, global_interrupt_enable)
		`CHK("table high byte", w[15:8], table_high_byte)
		`CHK("zero flag", 1'b1, zero_flag)
		`CHK("accumulator", 8'h00, acc)
		`CHK("carry flag", c, carry_flag)
		`CHK("auxiliary carry", hb[4], auxiliary_carry_flag)
		`CHK("overflow flag", ov_x, overflow_flag)
		`CHK("signed compare", sc_x, signed_compare_flag)
		`CHK("notes left", 0, q.size())
		wrap_up();
	end
endmodule : mit_core_tb_top
